// [design/pmcb_bank.sv]
// configuration register bank: pll override, oscillator select, power-down
// controls, lock alarm mode and two missing-reference period limits
// assumes the serial port engine hands byte writes and reads on the core clock
`timescale 1ns/10ps
module pmcb_bank
  import pmcb_pkg::*;
(
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_CE,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  input  wire logic [15:0] I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_PLL_LOCKED,
  input  wire logic        I_OUTPUTS_STABLE,
  output logic [7:0]       O_REG_RDATA,
  output logic             O_REG_RVALID,
  output logic             O_PLL_MANUAL_OVERRIDE,
  output logic [2:0]       O_OSCILLATOR_SELECT,
  output logic [4:0]       O_DIGITAL_LOCK_SETTING,
  output logic [1:0]       O_INPUT_REF_OFF,
  output logic             O_LOCK_ALARM_CLEAR_MODE,
  output logic             O_CRYSTAL_DOUBLER_OFF,
  output logic [3:0]       O_OUTPUT_PAIR_OFF,
  output logic [3:0]       O_OUTPUT_PAIR_OE,
  output logic             O_DIGITAL_LOOP_OFF,
  output logic             O_MODULATOR_OFF,
  output logic             O_CALIBRATION_HOLD,
  output logic             O_LOSS_OF_LOCK_ALARM,
  output logic [16:0]      O_REF0_MISSING_PERIOD_LIMIT,
  output logic [16:0]      O_REF1_MISSING_PERIOD_LIMIT
);

  logic        wr;
  logic        rd;
  logic        wr_ref0;
  logic        wr_ref1;
  pmcb_lane_t  lane_ref0;
  pmcb_lane_t  lane_ref1;
  logic [16:0] raw_ref0;
  logic [16:0] raw_ref1;
  logic [16:0] eff_ref0;
  logic [16:0] eff_ref1;
  logic        locked_q;
  logic        stable_q;
  logic        next_alarm;
  logic [7:0]  next_rdata;
  logic [2:0]  new_vco;

  // every access is frozen while the clock enable is low
  assign wr      = I_REG_WR && I_CE;
  assign rd      = I_REG_RD && I_CE;
  assign new_vco = I_REG_WDATA[POS_VCO_LSB +: 3];

  // limit decode uses the shared lane functions for both references
  assign wr_ref0   = wr && pmcb_in_limit(I_REG_ADDR, ADDR_REF0_HI);
  assign wr_ref1   = wr && pmcb_in_limit(I_REG_ADDR, ADDR_REF1_HI);
  assign lane_ref0 = pmcb_lane_of(I_REG_ADDR, ADDR_REF0_HI);
  assign lane_ref1 = pmcb_lane_of(I_REG_ADDR, ADDR_REF1_HI);

  // analog pll override and digital lock setting
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_PLL_MANUAL_OVERRIDE  <= RST_OVERRIDE;
      O_DIGITAL_LOCK_SETTING <= RST_DBIT;
    end
    else if (wr && I_REG_ADDR == ADDR_PLL_OVERRIDE)
      O_PLL_MANUAL_OVERRIDE <= I_REG_WDATA[POS_OVERRIDE];
    else if (wr && I_REG_ADDR == ADDR_PLL_VCO)
      O_DIGITAL_LOCK_SETTING <= I_REG_WDATA[POS_DBIT_LSB +: 5];
  end

  // a reserved oscillator code is dropped so the analog side never sees it
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_OSCILLATOR_SELECT <= RST_VCO;
    else if (wr && I_REG_ADDR == ADDR_PLL_VCO)
    begin
      if (new_vco == VCO_FIRST || new_vco == VCO_SECOND)
        O_OSCILLATOR_SELECT <= new_vco;
    end
  end

  // input reference power-down, one bit per reference
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_INPUT_REF_OFF <= {REF_N{RST_BIT}};
    else if (wr && I_REG_ADDR == ADDR_REF_OFF)
      O_INPUT_REF_OFF <= I_REG_WDATA[REF_N-1:0];
  end

  // lock alarm mode and crystal doubler
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_LOCK_ALARM_CLEAR_MODE <= RST_BIT;
      O_CRYSTAL_DOUBLER_OFF   <= RST_BIT;
    end
    else if (wr && I_REG_ADDR == ADDR_LOCK_DBL)
    begin
      O_LOCK_ALARM_CLEAR_MODE <= I_REG_WDATA[POS_LOCK_ALARM_CLEAR_MODE];
      O_CRYSTAL_DOUBLER_OFF   <= I_REG_WDATA[POS_DBL];
    end
  end

  // output pair power-down; the enable is the inverse so a disabled pair floats
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_OUTPUT_PAIR_OFF <= {OUT_N{RST_BIT}};
      O_OUTPUT_PAIR_OE  <= {OUT_N{~RST_BIT}};
    end
    else if (wr && I_REG_ADDR == ADDR_OUT_OFF)
    begin
      O_OUTPUT_PAIR_OFF <= I_REG_WDATA[OUT_N-1:0];
      O_OUTPUT_PAIR_OE  <= ~I_REG_WDATA[OUT_N-1:0];
    end
  end

  // digital loop, modulator and calibration controls
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      O_DIGITAL_LOOP_OFF <= RST_BIT;
      O_MODULATOR_OFF    <= RST_BIT;
      O_CALIBRATION_HOLD <= RST_BIT;
    end
    else if (wr && I_REG_ADDR == ADDR_MOD_CAL)
    begin
      O_DIGITAL_LOOP_OFF <= I_REG_WDATA[POS_DPLL];
      O_MODULATOR_OFF    <= I_REG_WDATA[POS_DSM];
      O_CALIBRATION_HOLD <= I_REG_WDATA[POS_CAL];
    end
  end

  // period limits for the two references
  pmcb_limit #(
    .RESET_VALUE (RST_LIMIT)
  ) u_limit_ref0 (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_wr    (wr_ref0),
    .i_lane  (lane_ref0),
    .i_wdata (I_REG_WDATA),
    .o_raw   (raw_ref0),
    .o_eff   (eff_ref0)
  );

  pmcb_limit #(
    .RESET_VALUE (RST_LIMIT)
  ) u_limit_ref1 (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_wr    (wr_ref1),
    .i_lane  (lane_ref1),
    .i_wdata (I_REG_WDATA),
    .o_raw   (raw_ref1),
    .o_eff   (eff_ref1)
  );

  // both limit outputs already leave a flip-flop inside the limit block
  assign O_REF0_MISSING_PERIOD_LIMIT = eff_ref0;
  assign O_REF1_MISSING_PERIOD_LIMIT = eff_ref1;

  // lock and stability come from the analog side, so they are synchronised
  pmcb_sync u_sync_locked (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_async (I_PLL_LOCKED),
    .o_level (locked_q)
  );

  pmcb_sync u_sync_stable (
    .i_clk   (I_CORE_CLK),
    .i_rst   (I_RST),
    .i_ce    (I_CE),
    .i_async (I_OUTPUTS_STABLE),
    .o_level (stable_q)
  );

  // alarm clears on lock, or in mode 1 only once outputs are stable too
  assign next_alarm = ~(locked_q && (~O_LOCK_ALARM_CLEAR_MODE || stable_q));

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_LOSS_OF_LOCK_ALARM <= RST_ALARM;
    else if (I_CE)
      O_LOSS_OF_LOCK_ALARM <= next_alarm;
  end

  // readback; reserved and unmapped positions return zero
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (I_REG_ADDR)
      ADDR_PLL_OVERRIDE: next_rdata[POS_OVERRIDE]      = O_PLL_MANUAL_OVERRIDE;
      ADDR_PLL_VCO:
      begin
        next_rdata[POS_VCO_LSB +: 3]  = O_OSCILLATOR_SELECT;
        next_rdata[POS_DBIT_LSB +: 5] = O_DIGITAL_LOCK_SETTING;
      end
      ADDR_REF_OFF:      next_rdata[REF_N-1:0]         = O_INPUT_REF_OFF;
      ADDR_LOCK_DBL:
      begin
        next_rdata[POS_LOCK_ALARM_CLEAR_MODE] = O_LOCK_ALARM_CLEAR_MODE;
        next_rdata[POS_DBL]     = O_CRYSTAL_DOUBLER_OFF;
      end
      ADDR_OUT_OFF:      next_rdata[OUT_N-1:0]         = O_OUTPUT_PAIR_OFF;
      ADDR_MOD_CAL:
      begin
        next_rdata[POS_DPLL] = O_DIGITAL_LOOP_OFF;
        next_rdata[POS_DSM]  = O_MODULATOR_OFF;
        next_rdata[POS_CAL]  = O_CALIBRATION_HOLD;
      end
      // raw value is shown so software reads back what it wrote
      ADDR_REF0_HI:      next_rdata[0]                 = raw_ref0[16];
      ADDR_REF0_MID:     next_rdata                    = raw_ref0[15:8];
      ADDR_REF0_LO:      next_rdata                    = raw_ref0[7:0];
      ADDR_REF1_HI:      next_rdata[0]                 = raw_ref1[16];
      ADDR_REF1_MID:     next_rdata                    = raw_ref1[15:8];
      ADDR_REF1_LO:      next_rdata                    = raw_ref1[7:0];
      default:           next_rdata                    = 8'h00;
    endcase
  end

  // read data is captured one cycle after the strobe and then held
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_REG_RDATA <= 8'h00;
    else if (rd)
      O_REG_RDATA <= next_rdata;
  end

  // read valid is a one-cycle pulse per accepted strobe
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
      O_REG_RVALID <= 1'h0;
    else if (I_CE)
      O_REG_RVALID <= I_REG_RD;
  end

  a_override_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_PLL_OVERRIDE) |=> (O_PLL_MANUAL_OVERRIDE == $past(I_REG_WDATA[0])))
    else $error("override bit not taken");

  a_vco_reserved_kept : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_PLL_VCO && new_vco > VCO_SECOND) |=> $stable(O_OSCILLATOR_SELECT))
    else $error("reserved oscillator code taken");

  a_vco_legal_only : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_OSCILLATOR_SELECT <= VCO_SECOND)
    else $error("oscillator select holds a reserved code");

  a_ref_off_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_REF_OFF) |=> (O_INPUT_REF_OFF == $past(I_REG_WDATA[1:0])))
    else $error("reference off bits not taken");

  a_alarm_lock_only : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (I_CE && locked_q && !O_LOCK_ALARM_CLEAR_MODE) |=> !O_LOSS_OF_LOCK_ALARM)
    else $error("alarm held after lock in mode 0");

  a_alarm_waits_stable : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (I_CE && O_LOCK_ALARM_CLEAR_MODE && !stable_q) |=> O_LOSS_OF_LOCK_ALARM)
    else $error("alarm cleared before outputs stable");

  a_doubler_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_LOCK_DBL) |=> (O_CRYSTAL_DOUBLER_OFF == $past(I_REG_WDATA[0])))
    else $error("doubler bit not taken");

  a_pair_float : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_OUTPUT_PAIR_OE == ~O_OUTPUT_PAIR_OFF)
    else $error("output enable does not follow pair off");

  a_power_ctrl_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_MOD_CAL) |=>
      ({O_DIGITAL_LOOP_OFF, O_MODULATOR_OFF, O_CALIBRATION_HOLD} == $past(I_REG_WDATA[2:0])))
    else $error("power controls not taken");

  a_reserved_read_zero : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (rd && (I_REG_ADDR == ADDR_RSVD_A || I_REG_ADDR == ADDR_RSVD_B)) |=> (O_REG_RDATA == 8'h00))
    else $error("reserved register read nonzero");

  // every accepted read strobe must answer on the next edge
  a_read_pulse : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    rd |=> O_REG_RVALID)
    else $error("read valid missing");

  a_rvalid_only_read : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (I_CE && !I_REG_RD) |=> !O_REG_RVALID)
    else $error("read valid without a read strobe");

  a_rdata_held : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !rd |=> $stable(O_REG_RDATA))
    else $error("read data moved without a read");

  // a low clock enable must freeze the override, oscillator, lock setting, reference, pair-off, alarm, read and raw limit state
  a_frozen_no_ce : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !I_CE |=> $stable({O_PLL_MANUAL_OVERRIDE, O_OSCILLATOR_SELECT, O_DIGITAL_LOCK_SETTING,
                       O_INPUT_REF_OFF, O_OUTPUT_PAIR_OFF, O_LOSS_OF_LOCK_ALARM,
                       O_REG_RDATA, O_REG_RVALID, raw_ref0, raw_ref1}))
    else $error("state changed while clock enable low");

  a_vco_legal_taken : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_PLL_VCO && new_vco <= VCO_SECOND) |=> (O_OSCILLATOR_SELECT == $past(new_vco)))
    else $error("legal oscillator code not taken");

  // the lock setting bits of a refused oscillator write still land
  a_dbit_always_taken : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_PLL_VCO) |=> (O_DIGITAL_LOCK_SETTING == $past(I_REG_WDATA[4:0])))
    else $error("digital lock setting not taken");

  a_pair_off_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_OUT_OFF) |=> (O_OUTPUT_PAIR_OFF == $past(I_REG_WDATA[3:0])))
    else $error("output pair off bits not taken");

  a_mode_write : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (wr && I_REG_ADDR == ADDR_LOCK_DBL) |=> (O_LOCK_ALARM_CLEAR_MODE == $past(I_REG_WDATA[1])))
    else $error("alarm clear mode not taken");

  a_alarm_clears : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (I_CE && locked_q && stable_q) |=> !O_LOSS_OF_LOCK_ALARM)
    else $error("alarm held although locked and stable");

  a_alarm_unlocked : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (I_CE && !locked_q) |=> O_LOSS_OF_LOCK_ALARM)
    else $error("alarm clear without lock");

  // a byte for reference 0 must never reach the reference 1 limit
  a_limit_lanes_apart : assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    wr_ref0 |=> $stable(raw_ref1))
    else $error("reference 0 write moved reference 1 limit");

endmodule

// [design/pmcb_pkg.sv]
// configuration register bank package: offsets, field positions, reset values
// assumes byte-wide registers on a 16-bit register address, one core clock
package pmcb_pkg;

  // bus geometry
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 8;
  localparam int LIMIT_W = 17;
  localparam int REF_N   = 2;
  localparam int OUT_N   = 4;
  localparam int SYNC_N  = 3;

  // register offsets
  localparam logic [15:0] ADDR_PLL_OVERRIDE = 16'h0069;
  localparam logic [15:0] ADDR_PLL_VCO      = 16'h006A;
  localparam logic [15:0] ADDR_REF_OFF      = 16'h006D;
  localparam logic [15:0] ADDR_LOCK_DBL     = 16'h006E;
  localparam logic [15:0] ADDR_OUT_OFF      = 16'h006F;
  localparam logic [15:0] ADDR_MOD_CAL      = 16'h0070;
  localparam logic [15:0] ADDR_REF0_HI      = 16'h0071;
  localparam logic [15:0] ADDR_REF0_MID     = 16'h0072;
  localparam logic [15:0] ADDR_REF0_LO      = 16'h0073;
  localparam logic [15:0] ADDR_REF1_HI      = 16'h0074;
  localparam logic [15:0] ADDR_REF1_MID     = 16'h0075;
  localparam logic [15:0] ADDR_REF1_LO      = 16'h0076;
  localparam logic [15:0] ADDR_RSVD_A       = 16'h0077;
  localparam logic [15:0] ADDR_RSVD_B       = 16'h0078;

  // field positions
  localparam int POS_OVERRIDE = 0;
  localparam int POS_VCO_LSB  = 5;
  localparam int POS_DBIT_LSB = 0;
  localparam int POS_DBL      = 0;
  localparam int POS_LOCK_ALARM_CLEAR_MODE  = 1;
  localparam int POS_CAL      = 0;
  localparam int POS_DSM      = 1;
  localparam int POS_DPLL     = 2;

  // values after reset and fixed codes
  localparam logic       RST_OVERRIDE = 1'h0;
  localparam logic [2:0] RST_VCO      = 3'h1;
  localparam logic [4:0] RST_DBIT     = 5'h0B;
  localparam logic       RST_BIT      = 1'h0;
  localparam logic       RST_ALARM    = 1'h1;
  localparam logic [2:0] VCO_FIRST    = 3'h0;
  localparam logic [2:0] VCO_SECOND   = 3'h1;
  localparam logic [16:0] RST_LIMIT   = 17'h1FFFF;
  localparam logic [16:0] LIMIT_MIN   = 17'h00003;

  // byte lane of a 17-bit limit inside its three addresses
  typedef enum logic [1:0] {PMCB_LANE_HI = 2'h0, PMCB_LANE_MID = 2'h1, PMCB_LANE_LO = 2'h2} pmcb_lane_t;

  // true when the address falls in the three bytes of a limit
  function automatic logic pmcb_in_limit(input logic [15:0] addr, input logic [15:0] base);
    pmcb_in_limit = (addr >= base) && (addr <= base + 16'h0002);
  endfunction

  // lane of an address inside a limit
  function automatic pmcb_lane_t pmcb_lane_of(input logic [15:0] addr, input logic [15:0] base);
    logic [15:0] diff;
    diff = addr - base;
    pmcb_lane_of = pmcb_lane_t'(diff[1:0]);
  endfunction

endpackage

// [design/pmcb_sync.sv]
// three-stage synchroniser with agreement filter for a level from a pin
// assumes the input is asynchronous to the core clock
`timescale 1ns/10ps
module pmcb_sync
  import pmcb_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_level
);

  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2, so a metastable first stage reaches no logic
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end
    else if (i_ce)
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_level <= 1'h0;
    else if (i_ce && (s2 == s3))
      o_level <= s3;
  end

endmodule

// [design/pmcb_limit.sv]
// one 17-bit missing-reference period limit spread over three byte addresses
// assumes the parent decodes the address and gives the byte lane
`timescale 1ns/10ps
module pmcb_limit
  import pmcb_pkg::*;
#(
  parameter logic [16:0] RESET_VALUE = RST_LIMIT
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_wr,
  input  wire pmcb_lane_t  i_lane,
  input  wire logic [7:0]  i_wdata,
  output logic [16:0]      o_raw,
  output logic [16:0]      o_eff
);

  // byte lanes: bit 16 alone, then 15..8, then 7..0
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_raw <= RESET_VALUE;
    else if (i_ce && i_wr)
    begin
      unique case (i_lane)
        PMCB_LANE_HI:  o_raw[16]   <= i_wdata[0];
        PMCB_LANE_MID: o_raw[15:8] <= i_wdata;
        PMCB_LANE_LO:  o_raw[7:0]  <= i_wdata;
        default:       o_raw       <= o_raw;
      endcase
    end
  end

  // a limit below the floor would flag a healthy reference, so clamp it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_eff <= RESET_VALUE;
    else if (i_ce)
      o_eff <= (o_raw < LIMIT_MIN) ? LIMIT_MIN : o_raw;
  end

  a_limit_floor : assert property (@(posedge i_clk) disable iff (i_rst) o_eff >= LIMIT_MIN)
    else $error("period limit below floor");

  a_limit_hi_lane : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_wr && i_lane == PMCB_LANE_HI) |=> (o_raw[16] == $past(i_wdata[0])))
    else $error("bit 16 not taken from high byte");

endmodule

// [verif/pmcb_tb.sv]
// self-checking bench for the configuration register bank
// assumes the bank alone on the core clock, reached by byte strobes only
`timescale 1ns/10ps
module testbench
  import pmcb_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        ce = 1'h1;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic        locked = 1'h0;
  logic        stable = 1'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        ovr;
  logic [2:0]  osc;
  logic [4:0]  dlk;
  logic [1:0]  refoff;
  logic        mode;
  logic        dbl;
  logic [3:0]  poff;
  logic [3:0]  poe;
  logic        dloop;
  logic        modoff;
  logic        cal;
  logic        loss_of_lock_alarm;
  logic [16:0] lim0;
  logic [16:0] lim1;
  logic [31:0] r;
  logic [2:0]  exp_osc;
  logic [16:0] v;
  logic [16:0] w;
  int          num_errors = 0;
  int          checks = 0;
  logic [7:0]  exp_q [$];
  // reset image of the map, ending with an address nobody decodes
  logic [15:0] rd_addr [0:13] = '{16'h0069, 16'h006A, 16'h006D, 16'h006E, 16'h006F, 16'h0070, 16'h0071,
                                  16'h0072, 16'h0073, 16'h0074, 16'h0075, 16'h0076, 16'h0077, 16'h0100};
  logic [7:0]  rd_exp [0:13] = '{8'h00, 8'h2B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00};

  pmcb_bank dut_u (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_PLL_LOCKED(locked), .I_OUTPUTS_STABLE(stable), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .O_PLL_MANUAL_OVERRIDE(ovr), .O_OSCILLATOR_SELECT(osc),
    .O_DIGITAL_LOCK_SETTING(dlk), .O_INPUT_REF_OFF(refoff), .O_LOCK_ALARM_CLEAR_MODE(mode),
    .O_CRYSTAL_DOUBLER_OFF(dbl), .O_OUTPUT_PAIR_OFF(poff), .O_OUTPUT_PAIR_OE(poe), .O_DIGITAL_LOOP_OFF(dloop),
    .O_MODULATOR_OFF(modoff), .O_CALIBRATION_HOLD(cal), .O_LOSS_OF_LOCK_ALARM(loss_of_lock_alarm),
    .O_REF0_MISSING_PERIOD_LIMIT(lim0), .O_REF1_MISSING_PERIOD_LIMIT(lim1)
  );

  // 100 MHz core clock
  always #5 clk = ~clk;

  // single comparison point, x never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // strobes stay up between calls so back-to-back bytes need no gap
  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    wr = 1'h1;
    rd = 1'h0;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_b(input logic [15:0] a, input logic [7:0] e);
    rd = 1'h1;
    wr = 1'h0;
    addr = a;
    exp_q.push_back(e);
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    wr = 1'h0;
    rd = 1'h0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  // read answers are matched in order; the valid pulse is sampled mid-cycle
  always @(negedge clk)
    if (rvalid === 1'b1)
      chk({24'h0, rdata}, exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h100);

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #100000;
    num_errors++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h4007));
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    idle(1);
    // reset values on the pins and through the read path
    chk(ovr, RST_OVERRIDE);
    chk(osc, RST_VCO);
    chk(dlk, RST_DBIT);
    chk({refoff, mode, dbl, poff, dloop, modoff, cal}, 32'h0);
    chk(poe, 32'hF);
    chk(loss_of_lock_alarm, RST_ALARM);
    chk(lim0, RST_LIMIT);
    chk(lim1, RST_LIMIT);
    for (int i = 0; i < 14; i++)
      rd_b(rd_addr[i], rd_exp[i]);
    idle(2);
    $display("test reset_values done");
    // random control bits, reserved positions always written zero
    for (int i = 0; i < 20; i++)
    begin
      r = $urandom;
      wr_b(ADDR_PLL_OVERRIDE, {7'h0, r[0]});
      wr_b(ADDR_REF_OFF, {6'h0, r[2:1]});
      wr_b(ADDR_LOCK_DBL, {6'h0, r[4:3]});
      wr_b(ADDR_OUT_OFF, {4'h0, r[8:5]});
      wr_b(ADDR_MOD_CAL, {5'h0, r[11:9]});
      idle(1);
      chk(ovr, r[0]);
      chk(refoff, r[2:1]);
      chk(dbl, r[3]);
      chk(mode, r[4]);
      chk(poff, r[8:5]);
      chk(poe, {~r[8:5]});
      chk(cal, r[9]);
      chk(modoff, r[10]);
      chk(dloop, r[11]);
      rd_b(ADDR_PLL_OVERRIDE, {7'h0, r[0]});
      rd_b(ADDR_REF_OFF, {6'h0, r[2:1]});
      rd_b(ADDR_LOCK_DBL, {6'h0, r[4:3]});
      rd_b(ADDR_OUT_OFF, {4'h0, r[8:5]});
      rd_b(ADDR_MOD_CAL, {5'h0, r[11:9]});
      idle(2);
    end
    // a write with the clock enable low must leave the pair state alone
    ce = 1'h0;
    wr_b(ADDR_OUT_OFF, {4'h0, ~r[8:5]});
    ce = 1'h1;
    idle(1);
    chk(poff, r[8:5]);
    $display("test control_bits done");
    // every oscillator code; order c^1 makes a refused code show against 000
    exp_osc = RST_VCO;
    for (int c = 0; c < 8; c++)
    begin
      r = $urandom;
      wr_b(ADDR_PLL_VCO, {3'(c ^ 1), r[4:0]});
      idle(1);
      if ((c ^ 1) < 2)
        exp_osc = 3'(c ^ 1);
      chk(osc, exp_osc);
      chk(dlk, r[4:0]);
      rd_b(ADDR_PLL_VCO, {exp_osc, r[4:0]});
      idle(2);
    end
    $display("test oscillator_select done");
    // limits: values up to the floor first, then random; ref1 differs to catch crossed lanes
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 4) ? 17'(i) : 17'($urandom);
      w = (i < 4) ? 17'(3 - i) : ~v;
      wr_b(ADDR_REF0_HI, {7'h0, v[16]});
      wr_b(ADDR_REF0_MID, v[15:8]);
      wr_b(ADDR_REF0_LO, v[7:0]);
      wr_b(ADDR_REF1_HI, {7'h0, w[16]});
      wr_b(ADDR_REF1_MID, w[15:8]);
      wr_b(ADDR_REF1_LO, w[7:0]);
      idle(2);
      chk(lim0, (v < LIMIT_MIN) ? LIMIT_MIN : v);
      chk(lim1, (w < LIMIT_MIN) ? LIMIT_MIN : w);
      rd_b(ADDR_REF0_HI, {7'h0, v[16]});
      rd_b(ADDR_REF0_MID, v[15:8]);
      rd_b(ADDR_REF0_LO, v[7:0]);
      rd_b(ADDR_REF1_HI, {7'h0, w[16]});
      rd_b(ADDR_REF1_MID, w[15:8]);
      rd_b(ADDR_REF1_LO, w[7:0]);
      idle(2);
    end
    $display("test period_limits done");
    // alarm against every mode, lock and stability combination
    for (int i = 0; i < 8; i++)
    begin
      locked = i[1];
      stable = i[0];
      wr_b(ADDR_LOCK_DBL, {6'h0, i[2], 1'h0});
      idle(8);
      chk(loss_of_lock_alarm, {~(i[1] & (~i[2] | i[0]))});
    end
    $display("test lock_alarm done");
    // a mid-run reset wins over a low clock enable and clears the synchronisers
    wr_b(ADDR_OUT_OFF, 8'h0F);
    idle(1);
    ce = 1'h0;
    rst = 1'h1;
    idle(2);
    ce = 1'h1;
    rst = 1'h0;
    idle(1);
    chk(poff, 32'h0);
    chk(poe, 32'hF);
    chk(osc, RST_VCO);
    chk(lim0, RST_LIMIT);
    chk(loss_of_lock_alarm, RST_ALARM);
    rd_b(ADDR_REF0_LO, 8'hFF);
    idle(2);
    $display("test mid_reset done");
    idle(3);
    chk(exp_q.size(), 32'h0);
    conclude();
  end
endmodule
